// ===== src/lic_consts.svh
// Purpose: offsets, field positions and reset values of the local interrupt controller
// Assumes: byte addresses on the wishbone bus, 32-bit data
// Notes: included by the design, the assertions and the bench
`ifndef LIC_CONSTS_SVH
`define LIC_CONSTS_SVH

// wishbone register map
`define LIC_WB_MODE      8'h00
`define LIC_WB_STATUS    8'h04
`define LIC_WB_WIN_ADDR  8'h08
`define LIC_WB_WIN_DATA  8'h0C
`define LIC_WB_MSPATH_ADDR 8'h10
`define LIC_WB_MSPATH_DATA 8'h14

// mode control bit
`define LIC_MODE_BIT     0

// memory-mapped window: one 4 KB page
`define LIC_WIN_BYTES    32'h0000_1000
`define LIC_WIN_AW       12

// slot field: window offset bits, model-specific path index low bits
`define LIC_SLOT_LSB     4
`define LIC_SLOT_W       4

// tpr width
`define LIC_TPR_W        8

// register slots (window byte offset / 16, model-specific path index low bits)
`define LIC_SLOT_ID      4'h2
`define LIC_SLOT_VER     4'h3
`define LIC_SLOT_TPR     4'h8
`define LIC_SLOT_LDR     4'hD
`define LIC_SLOT_DFR     4'hF

// field positions
`define LIC_LEG_ID_LSB   24
`define LIC_CLUSTER_LSB  16
`define LIC_LEG_ID_W     8

// reset values
`define LIC_RST_DFR      32'hFFFF_FFFF
// version word: arbitrary value
`define LIC_VER_VAL      32'h0000_00A5

// status bits
`define LIC_ST_MODE      0
`define LIC_ST_WIN_ERR   1
`define LIC_ST_MSPATH_ERR 2

`endif

// ===== src/lic_pkg.sv
// Purpose: types shared by the local interrupt controller
// Assumes: lic_consts.svh holds the numbers
// Notes: no constants here beyond types
package lic_pkg;

  // wishbone request bundle
  typedef struct packed {
    logic       cyc;
    logic       stb;
    logic       we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } wb_req_t;

  // internal register access
  typedef struct packed {
    logic       wr;
    logic [3:0] slot;
    logic [31:0] dat;
  } reg_acc_t;

  typedef enum logic [1:0] {
    MODE_LEGACY = 2'b01,
    MODE_EXT    = 2'b10
  } lic_mode_t;

endpackage

// ===== src/local_intr_ctrl.sv
// Purpose: register access and addressing layer of a local interrupt controller
// Assumes: wishbone classic slave, one clock, async active-low reset
// Notes: window and model-specific paths are indirect through address/data registers
//
// How it works
// - legacy mode serves the register set through a 4 KB memory-mapped window
// - extended mode serves every register access through the model-specific path
// - extended mode refuses window accesses; status flags the refusal
// - physical id is 8 bits in legacy mode, 32 bits in extended mode
// - extended logical id is 16-bit cluster plus 16-bit in-cluster id
// - unimplemented upper physical id bits read zero, writes ignored
// - narrower cluster and logical fields read zero above, writes ignored
// - priority register behaves alike in both modes; destination format reads zero, writes ignored in extended mode
`timescale 1ns/1ps
`include "lic_consts.svh"

module local_intr_ctrl #(
  parameter int PHYS_ID_W = 32,
  parameter int CLUSTER_W = 16,
  parameter int LOG_ID_W = 16,
  parameter logic [31:0] PHYS_ID_INIT = 32'h0000_0001
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // mode and ids to the delivery logic
  output logic extended_id_mode_o,
  output logic [31:0] phys_id_o,
  output logic [31:0] logical_id_o
);

  // ****************************************
  // state
  // ****************************************
  lic_pkg::wb_req_t req;
  lic_pkg::reg_acc_t acc;
  lic_pkg::lic_mode_t mode_reg, mode_next;
  logic [31:0] win_addr_reg, win_addr_next;
  logic [31:0] mspath_addr_reg, mspath_addr_next;
  logic [31:0] phys_id_reg, phys_id_next;
  logic [31:0] ldr_reg, ldr_next;
  logic [31:0] dfr_reg, dfr_next;
  logic [31:0] tpr_reg, tpr_next;
  logic win_err_reg, win_err_next;
  logic mspath_err_reg, mspath_err_next;
  logic ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  logic [31:0] slot_rd;
  logic [31:0] phys_mask, ldr_mask;
  logic ext;
  logic go, acc_en, win_hit, win_sel, mspath_sel;

  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                 adr: wb_adr_i, dat: wb_dat_i};
  assign ext = (mode_reg == lic_pkg::MODE_EXT);
  assign go = req.cyc && req.stb && !ack_reg;
  assign phys_mask = (PHYS_ID_W >= 32) ? 32'hFFFF_FFFF :
                     ((32'h1 << PHYS_ID_W) - 32'h1);
  assign ldr_mask = (((32'h1 << CLUSTER_W) - 32'h1) << `LIC_CLUSTER_LSB) |
                    ((32'h1 << LOG_ID_W) - 32'h1);

  // ****************************************
  // register set decode
  // ****************************************
  assign win_sel = (req.adr == `LIC_WB_WIN_DATA);
  assign mspath_sel = (req.adr == `LIC_WB_MSPATH_DATA);
  // window covers one 4 KB page
  assign win_hit = (win_addr_reg < `LIC_WIN_BYTES);
  assign acc_en = go && ((win_sel && !ext && win_hit)
                         || (mspath_sel && ext));
  assign acc.wr = req.we && req.sel[0];
  assign acc.slot = win_sel ? win_addr_reg[`LIC_SLOT_LSB +: `LIC_SLOT_W]
                            : mspath_addr_reg[`LIC_SLOT_W-1:0];
  assign acc.dat = req.dat;

  always_comb begin
    slot_rd = 32'h0;
    unique case (acc.slot)
      `LIC_SLOT_ID: begin
        if (ext) begin
          slot_rd = phys_id_reg & phys_mask;
        end else begin
          slot_rd = {phys_id_reg[`LIC_LEG_ID_W-1:0], 24'h0};
        end
      end
      `LIC_SLOT_VER: slot_rd = `LIC_VER_VAL;
      `LIC_SLOT_TPR: slot_rd = tpr_reg;
      `LIC_SLOT_LDR: begin
        if (ext) begin
          slot_rd = ldr_reg & ldr_mask;
        end else begin
          slot_rd = {ldr_reg[`LIC_LEG_ID_W-1:0], 24'h0};
        end
      end
      `LIC_SLOT_DFR: slot_rd = ext ? 32'h0 : dfr_reg;
      default: slot_rd = 32'h0;
    endcase
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    mode_next = mode_reg;
    win_addr_next = win_addr_reg;
    mspath_addr_next = mspath_addr_reg;
    phys_id_next = phys_id_reg;
    ldr_next = ldr_reg;
    dfr_next = dfr_reg;
    tpr_next = tpr_reg;
    win_err_next = win_err_reg;
    mspath_err_next = mspath_err_reg;
    ack_next = go;
    rdat_next = 32'h0;
    if (go && req.we && req.sel[0]) begin
      unique case (req.adr)
        `LIC_WB_MODE: begin
          // software write only
          mode_next = req.dat[`LIC_MODE_BIT] ? lic_pkg::MODE_EXT
                                             : lic_pkg::MODE_LEGACY;
        end
        `LIC_WB_STATUS: begin
          win_err_next = win_err_reg & ~req.dat[`LIC_ST_WIN_ERR];
          mspath_err_next = mspath_err_reg & ~req.dat[`LIC_ST_MSPATH_ERR];
        end
        `LIC_WB_WIN_ADDR: win_addr_next = req.dat;
        `LIC_WB_MSPATH_ADDR: mspath_addr_next = req.dat;
        default: ;
      endcase
    end
    if (go && !req.we) begin
      unique case (req.adr)
        `LIC_WB_MODE: rdat_next[`LIC_MODE_BIT] = ext;
        `LIC_WB_STATUS: begin
          rdat_next[`LIC_ST_MODE] = ext;
          rdat_next[`LIC_ST_WIN_ERR] = win_err_reg;
          rdat_next[`LIC_ST_MSPATH_ERR] = mspath_err_reg;
        end
        `LIC_WB_WIN_ADDR: rdat_next = win_addr_reg;
        `LIC_WB_MSPATH_ADDR: rdat_next = mspath_addr_reg;
        `LIC_WB_WIN_DATA, `LIC_WB_MSPATH_DATA: rdat_next = acc_en ? slot_rd : 32'h0;
        default: rdat_next = 32'h0;
      endcase
    end
    if (acc_en && acc.wr) begin
      unique case (acc.slot)
        `LIC_SLOT_ID: begin
          if (ext) begin
            phys_id_next = acc.dat & phys_mask;
          end else begin
            phys_id_next = {24'h0, acc.dat[`LIC_LEG_ID_LSB +: `LIC_LEG_ID_W]};
          end
        end
        `LIC_SLOT_TPR: tpr_next = {24'h0, acc.dat[`LIC_TPR_W-1:0]};
        `LIC_SLOT_LDR: begin
          if (ext) begin
            ldr_next = acc.dat & ldr_mask;
          end else begin
            ldr_next = {24'h0, acc.dat[`LIC_LEG_ID_LSB +: `LIC_LEG_ID_W]};
          end
        end
        `LIC_SLOT_DFR: begin
          if (!ext) begin
            dfr_next = acc.dat;
          end
        end
        default: ;
      endcase
    end
    // refused accesses flag; set wins over clear
    if (go && win_sel && (ext || !win_hit)) begin
      win_err_next = 1'b1;
    end
    if (go && mspath_sel && !ext) begin
      mspath_err_next = 1'b1;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_reg <= lic_pkg::MODE_LEGACY;
      win_addr_reg <= 32'h0;
      mspath_addr_reg <= 32'h0;
      phys_id_reg <= PHYS_ID_INIT;
      ldr_reg <= 32'h0;
      dfr_reg <= `LIC_RST_DFR;
      tpr_reg <= 32'h0;
      win_err_reg <= 1'b0;
      mspath_err_reg <= 1'b0;
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0;
    end else begin
      mode_reg <= mode_next;
      win_addr_reg <= win_addr_next;
      mspath_addr_reg <= mspath_addr_next;
      phys_id_reg <= phys_id_next;
      ldr_reg <= ldr_next;
      dfr_reg <= dfr_next;
      tpr_reg <= tpr_next;
      win_err_reg <= win_err_next;
      mspath_err_reg <= mspath_err_next;
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  logic ext_out_reg, ext_out_next;
  logic [31:0] phys_out_reg, phys_out_next;
  logic [31:0] log_out_reg, log_out_next;

  always_comb begin
    ext_out_next = ext;
    phys_out_next = ext ? (phys_id_reg & phys_mask)
                        : {24'h0, phys_id_reg[`LIC_LEG_ID_W-1:0]};
    log_out_next = ext ? (ldr_reg & ldr_mask)
                       : {24'h0, ldr_reg[`LIC_LEG_ID_W-1:0]};
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_out_reg <= 1'b0;
      phys_out_reg <= 32'h0;
      log_out_reg <= 32'h0;
    end else begin
      ext_out_reg <= ext_out_next;
      phys_out_reg <= phys_out_next;
      log_out_reg <= log_out_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;
  assign extended_id_mode_o = ext_out_reg;
  assign phys_id_o = phys_out_reg;
  assign logical_id_o = log_out_reg;

endmodule

// ===== tb/lic_asserts.sv
// Purpose: port checks of the local interrupt controller
// Assumes: sees the top ports only
// Notes: bound to every instance below
`timescale 1ns/1ps
`include "lic_consts.svh"
module lic_asserts #(
  parameter int PHYS_ID_W = 32,
  parameter int CLUSTER_W = 16,
  parameter int LOG_ID_W = 16
) (
  // clock, reset and bus
  input wire logic ref_clk_i, nrst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic [7:0] wb_adr_i,
  // data and ids
  input wire logic extended_id_mode_o,
  input wire logic [31:0] wb_dat_i, wb_dat_o, phys_id_o, logical_id_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  // a request taken at this edge
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_read(logic [7:0] a);
    s_take ##0 (!wb_we_i && wb_adr_i == a);
  endsequence
  chk_ack_follows: assert property (s_take |=> wb_ack_o)
    else $error("ack missing");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  chk_no_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  chk_win_refused: assert property (s_read(`LIC_WB_WIN_DATA) ##0 extended_id_mode_o
    |=> wb_dat_o == 32'h0) else $error("window served in extended mode");
  chk_mspath_legacy: assert property (s_read(`LIC_WB_MSPATH_DATA)
    ##0 !extended_id_mode_o ##0 $past(extended_id_mode_o) == 1'b0 |=> wb_dat_o == 32'h0)
    else $error("model-specific access served in legacy mode");
  chk_leg_id_width: assert property (!extended_id_mode_o [*3] |->
    phys_id_o[31:8] == 24'h0) else $error("legacy id wide");
  chk_phys_id_mask: assert property (extended_id_mode_o [*3] |->
    (phys_id_o >> PHYS_ID_W) == 0) else $error("phys id upper bits");
  chk_cluster_mask: assert property (extended_id_mode_o [*3] |->
    (logical_id_o[31:16] >> CLUSTER_W) == 0 && (logical_id_o[15:0] >> LOG_ID_W) == 0)
    else $error("logical id upper bits");
  chk_mode_cause: assert property ($rose(extended_id_mode_o) |->
    wb_ack_o || $past(wb_ack_o) || $past(wb_ack_o, 2)) else $error("mode change unasked");
endmodule
bind local_intr_ctrl lic_asserts #(.PHYS_ID_W(PHYS_ID_W), .CLUSTER_W(CLUSTER_W),
  .LOG_ID_W(LOG_ID_W)) chk_u (.ref_clk_i, .nrst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o,
  .wb_sel_i, .wb_adr_i, .extended_id_mode_o, .wb_dat_i, .wb_dat_o, .phys_id_o, .logical_id_o);

// ===== tb/sw_master.sv
// Purpose: core software as a classic wishbone master
// Assumes: slave acks from a registered flop
// Notes: released lines show inverted values
`timescale 1ns/1ps
module sw_master (
  input wire logic ref_clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output lic_pkg::wb_req_t req_o
);
  initial req_o = '0;
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
      output logic [31:0] rd);
    @(posedge ref_clk_i);
    req_o <= '{1'b1, 1'b1, we, 4'hF, adr, dat};
    @(posedge ref_clk_i);
    while (ack_i !== 1'b1) @(posedge ref_clk_i);
    rd = dat_i;
    req_o <= '{1'b0, 1'b0, ~we, 4'h0, ~adr, ~dat};
    @(posedge ref_clk_i);
  endtask
endmodule

// ===== tb/local_intr_ctrl_ext_id_mode_tb.sv
// Purpose: self-checking bench of the local interrupt controller
// Assumes: narrowed id widths 20, 8 and 12
// Notes: table of bus cycles, then a mid-run reset
`timescale 1ns/1ps
`include "lic_consts.svh"
module local_intr_ctrl_ext_id_mode_tb;
  typedef struct packed {logic we; logic [7:0] adr; logic [31:0] dat; logic [31:0] exp;} row_t;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic ack, ext;
  logic [31:0] rdat, phys, logi, rd;
  lic_pkg::wb_req_t req;
  int mismatches = 0, compares = 0, cyc_n = 0;
  row_t rows [27];
  local_intr_ctrl #(.PHYS_ID_W(20), .CLUSTER_W(8), .LOG_ID_W(12)) dut_u (.ref_clk_i, .nrst_i,
    .wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_we_i(req.we), .wb_sel_i(req.sel),
    .wb_adr_i(req.adr), .wb_dat_i(req.dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .extended_id_mode_o(ext), .phys_id_o(phys), .logical_id_o(logi));
  sw_master sw_u (.ref_clk_i, .ack_i(ack), .dat_i(rdat), .req_o(req));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial forever #50 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cyc_n++;
    if (cyc_n == 2000) begin
      mismatches++;
      results();
    end
  end
  initial begin
    rows = '{'{0, 8'h00, 32'h0, 32'h0}, '{1, 8'h08, 32'h20, 32'h0}, '{1, 8'h0C, 32'hAB00_0000,
      32'h0}, '{0, 8'h0C, 32'h0, 32'hAB00_0000}, '{1, 8'h08, 32'h1000, 32'h0},
      '{0, 8'h0C, 32'h0, 32'h0}, '{0, 8'h04, 32'h0, 32'h2}, '{1, 8'h08, 32'h30, 32'h0},
      '{0, 8'h0C, 32'h0, `LIC_VER_VAL}, '{1, 8'h10, 32'h2, 32'h0}, '{0, 8'h14, 32'h0, 32'h0},
      '{0, 8'h04, 32'h0, 32'h6}, '{1, 8'h00, 32'h1, 32'h0}, '{0, 8'h04, 32'h0, 32'h7},
      '{0, 8'h0C, 32'h0, 32'h0}, '{1, 8'h14, 32'h1234_5678, 32'h0},
      '{0, 8'h14, 32'h0, 32'h0004_5678}, '{1, 8'h10, 32'h8, 32'h0}, '{1, 8'h14, 32'h1FF, 32'h0},
      '{0, 8'h14, 32'h0, 32'hFF}, '{0, 8'h40, 32'h0, 32'h0}, '{1, 8'h00, 32'h0, 32'h0},
      '{0, 8'h0C, 32'h0, `LIC_VER_VAL}, '{1, 8'h00, 32'h1, 32'h0}, '{1, 8'h10, 32'hD, 32'h0},
      '{1, 8'h14, 32'hFFFF_FFFF, 32'h0}, '{0, 8'h14, 32'h0, 32'h00FF_0FFF}};
    repeat (8) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    foreach (rows[i]) begin
      sw_u.xfer(rows[i].we, rows[i].adr, rows[i].dat, rd);
      check($sformatf("row %0d", i), rows[i].exp, rd);
    end
    check("mode out ext", 32'h1, {31'h0, ext});
    check("phys id out", 32'h0004_5678, phys);
    check("logical id out", 32'h00FF_0FFF, logi);
    $display("table test done");
    sw_u.xfer(1'b1, 8'h00, 32'h1, rd);
    nrst_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    check("mode out", 32'h0, {31'h0, ext});
    nrst_i <= 1'b1;
    sw_u.xfer(1'b0, 8'h00, 32'h0, rd);
    check("mode reg", 32'h0, rd);
    check("logical out after reset", 32'h0, logi);
    $display("reset test done");
    results();
  end
endmodule
